// ==== src/adcc_axil_slave.sv ====
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
`default_nettype none
module adcc_axil_slave
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [31:0] wr_mask,
  input wire logic wr_err,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_full_q, w_full_q, ar_full_q;
  logic take_aw, take_w, take_ar;
  logic [3:0] wstrb_q;

  assign take_aw = s_awvalid && s_awready;
  assign take_w = s_wvalid && s_wready;
  assign take_ar = s_arvalid && s_arready;
  // Address and data may arrive in either order
  assign wr_en = aw_full_q && w_full_q && !s_bvalid;
  assign rd_en = ar_full_q && !s_rvalid;
  assign wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (take_aw)
        wr_addr <= s_awaddr;
      if (take_w)
      begin
        wr_data <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      aw_full_q <= take_aw || (aw_full_q && !wr_en);
      w_full_q <= take_w || (w_full_q && !wr_en);
      s_awready <= !(take_aw || (aw_full_q && !wr_en));
      s_wready <= !(take_w || (w_full_q && !wr_en));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_full_q <= 1'b0;
      s_arready <= 1'b0;
      rd_addr <= '0;
    end
    else
    begin
      if (take_ar)
        rd_addr <= s_araddr;
      ar_full_q <= take_ar || (ar_full_q && !rd_en);
      s_arready <= !(take_ar || (ar_full_q && !rd_en));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_err ? 32'h00000000 : rd_data;
      s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end
endmodule // adcc_axil_slave
`default_nettype wire

// ==== src/adcc_ctrl.sv ====
// Converter control, configuration, result and DMA request logic
//
// Notes on behaviour
// - On request sets only when control register is all zero; hardware clears.
// - Off request sets only when on and no start; powers converter down.
// - Start request sets only when on and no off pending; cleared at idle.
// - Stop request sets only while start active, no off pending.
// - Calibration request sets only while disabled; cleared when calibration done.
// - Config bit 1 selects single or circular DMA, only with DMA on.
// - Config bit 2 picks upward or downward channel scan order.
// - Config bits 4:3 pick 12, 10, 8 or 6 bit resolution.
// - Config bit 5 picks right or left result alignment.
// - Config bits 8:6 pick one of eight external trigger events.
// - Config bits 11:10: software start, rising, falling or both edges.
// - Config bit 12: on overrun keep old result or overwrite.
// - With DMA on, one request after each completed conversion; single mode only until the run ends.
// - Unserviced request raises overrun; no requests until flag cleared.
// - Config writes taken only while no conversion start is active.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NUM_TRG = 8
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Analog core handshakes
  input wire logic core_ready,
  input wire logic core_off_done,
  input wire logic core_cal_done,
  input wire logic core_eoc,
  input wire logic [11:0] core_result,
  input wire logic core_idle,
  output logic core_power_on,
  output logic core_cal_run,
  output logic core_start_pulse,
  output logic core_stop_pulse,
  output logic core_scan_down,
  output logic [1:0] core_resolution,
  // External triggers
  input wire logic [NUM_TRG-1:0] ext_trig,
  // DMA request
  output logic dma_req,
  output logic dma_circular,
  input wire logic dma_ack,
  // Interrupt
  output logic irq
);
  generate
    if (ADDR_W < 7 || ADDR_W > 32)
    begin : g_bad_addr
      $error("adcc_ctrl: ADDR_W must be 7 to 32");
    end
    if (NUM_TRG != 8)
    begin : g_bad_trg
      $error("adcc_ctrl: trigger field holds exactly eight events");
    end
  endgenerate

  logic wr_en, rd_en, wr_err, rd_err, trig_hit;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, wr_mask, rd_data, wset;
  logic [31:0] ctrl_q, cfg_q;
  logic [7:0] sts_q, ien_q, sts_set;
  logic [15:0] data_q;
  logic data_pend_q, dma_armed_q, ovr_now;
  logic wr_ctrl, wr_cfg, wr_sts, wr_ien, rd_data_reg;
  logic on_set, off_set, start_set, stop_set, cal_set;
  logic [1:0] res_sel;
  logic [11:0] res_masked;

  adcc_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  adcc_trig_detect #(
    .NUM_TRG(NUM_TRG)
  ) u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_trig(ext_trig),
    .trigger_source_select(cfg_q[CFG_TRG_LO +: 3]),
    .trigger_edge_select(cfg_q[CFG_EDGE_LO +: 2]),
    .trig_hit(trig_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wset = wr_data & wr_mask;
  assign wr_ctrl = wr_en && wr_addr == ADDR_W'(ADDR_CTRL);
  assign wr_cfg = wr_en && wr_addr == ADDR_W'(ADDR_CFG1);
  assign wr_sts = wr_en && wr_addr == ADDR_W'(ADDR_STS);
  assign wr_ien = wr_en && wr_addr == ADDR_W'(ADDR_IEN);
  assign wr_err = !(wr_ctrl || wr_cfg || wr_sts || wr_ien ||
                    wr_addr == ADDR_W'(ADDR_DATA));
  assign rd_data_reg = rd_en && rd_addr == ADDR_W'(ADDR_DATA);

  always_comb
  begin
    rd_err = 1'b0;
    case (rd_addr)
      ADDR_W'(ADDR_STS): rd_data = {24'h000000, sts_q};
      ADDR_W'(ADDR_IEN): rd_data = {24'h000000, ien_q};
      ADDR_W'(ADDR_CTRL): rd_data = ctrl_q;
      ADDR_W'(ADDR_CFG1): rd_data = cfg_q;
      ADDR_W'(ADDR_DATA): rd_data = {16'h0000, data_q};
      default:
      begin
        rd_data = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Request preconditions, judged on the value before this write
  assign on_set = wset[CTRL_ON] && ctrl_q == 32'h00000000;
  assign off_set = wset[CTRL_OFF] && ctrl_q[CTRL_ON] &&
                   !ctrl_q[CTRL_START];
  assign start_set = wset[CTRL_START] && ctrl_q[CTRL_ON] &&
                     !ctrl_q[CTRL_OFF];
  assign stop_set = wset[CTRL_STOP] && ctrl_q[CTRL_START] &&
                    !ctrl_q[CTRL_OFF];
  assign cal_set = wset[CTRL_CAL] && !ctrl_q[CTRL_ON];

  // Hardware clears first so a software set in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= CTRL_RESET;
    else
    begin
      if (core_off_done)
      begin
        ctrl_q[CTRL_ON] <= 1'b0;
        ctrl_q[CTRL_OFF] <= 1'b0;
      end
      if (core_idle)
      begin
        ctrl_q[CTRL_START] <= 1'b0;
        ctrl_q[CTRL_STOP] <= 1'b0;
      end
      if (core_cal_done)
        ctrl_q[CTRL_CAL] <= 1'b0;
      if (wr_ctrl)
      begin
        if (on_set)
          ctrl_q[CTRL_ON] <= 1'b1;
        if (off_set)
          ctrl_q[CTRL_OFF] <= 1'b1;
        if (start_set)
          ctrl_q[CTRL_START] <= 1'b1;
        if (stop_set)
          ctrl_q[CTRL_STOP] <= 1'b1;
        if (cal_set)
          ctrl_q[CTRL_CAL] <= 1'b1;
      end
    end
  end

  // Start goes out at once in software mode, else on each trigger edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_start_pulse <= 1'b0;
      core_stop_pulse <= 1'b0;
      core_power_on <= 1'b0;
      core_cal_run <= 1'b0;
    end
    else
    begin
      core_start_pulse <= (wr_ctrl && start_set &&
                           cfg_q[CFG_EDGE_LO +: 2] == EDGE_NONE) ||
                          (ctrl_q[CTRL_START] && !ctrl_q[CTRL_STOP] &&
                           trig_hit);
      core_stop_pulse <= wr_ctrl && stop_set;
      core_power_on <= ctrl_q[CTRL_ON] && !ctrl_q[CTRL_OFF];
      core_cal_run <= ctrl_q[CTRL_CAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration; refused while a start is active
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q <= CFG1_RESET;
    else if (wr_cfg && !ctrl_q[CTRL_START])
      cfg_q <= (wr_data & wr_mask & CFG_WMASK) |
               (cfg_q & ~wr_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_scan_down <= 1'b0;
      core_resolution <= 2'h0;
      dma_circular <= 1'b0;
    end
    else
    begin
      core_scan_down <= cfg_q[CFG_SCAN_DOWN];
      core_resolution <= cfg_q[CFG_RES_LO +: 2];
      dma_circular <= cfg_q[CFG_DMA_EN] && cfg_q[CFG_DMA_CIRC];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result formatting and overrun
  assign res_sel = cfg_q[CFG_RES_LO +: 2];
  assign res_masked = core_result & (12'hfff >> {res_sel, 1'b0});
  assign ovr_now = core_eoc && (data_pend_q || dma_req);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_q <= 16'h0000;
    else if (core_eoc && (!ovr_now || cfg_q[CFG_OVR_OVERWRITE]))
    begin
      if (cfg_q[CFG_ALIGN_LEFT])
        data_q <= {res_masked, 4'h0} << {res_sel, 1'b0};
      else
        data_q <= {4'h0, res_masked};
    end
  end

  // New result wins over a read or acknowledge in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_pend_q <= 1'b0;
    else if (core_eoc)
      data_pend_q <= 1'b1;
    else if (rd_data_reg || dma_ack)
      data_pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // DMA requests; single mode stops after one run until re-enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_armed_q <= 1'b0;
    else if (wr_cfg && !ctrl_q[CTRL_START])
      dma_armed_q <= wset[CFG_DMA_EN];
    else if (core_idle && !cfg_q[CFG_DMA_CIRC])
      dma_armed_q <= 1'b0;
  end

  // An overrun withdraws the request, its data may be gone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_req <= 1'b0;
    else if (ovr_now || !cfg_q[CFG_DMA_EN])
      dma_req <= 1'b0;
    else if (core_eoc && dma_armed_q && !sts_q[STS_OVR])
      dma_req <= 1'b1;
    else if (dma_ack)
      dma_req <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear, set wins
  always_comb
  begin
    sts_set = 8'h00;
    sts_set[STS_READY] = core_ready;
    sts_set[STS_EOC] = core_eoc;
    sts_set[STS_OVR] = ovr_now;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sts
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          sts_q[gi] <= 1'b0;
        else if (!STS_IMPL[gi])
          sts_q[gi] <= 1'b0;
        else if (sts_set[gi])
          sts_q[gi] <= 1'b1;
        else if (wr_sts && wset[gi])
          sts_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ien_q <= 8'h00;
    else if (wr_ien)
      ien_q <= (wr_data[7:0] & wr_mask[7:0] & STS_IMPL) |
               (ien_q & ~wr_mask[7:0]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(sts_q & ien_q);
  end
endmodule // adcc_ctrl
`default_nettype wire

// ==== src/adcc_pkg.sv ====
// Constants shared by the converter control block
package adcc_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_STS = 12'h000;
  localparam logic [11:0] ADDR_IEN = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_CFG1 = 12'h00c;
  localparam logic [11:0] ADDR_DATA = 12'h040;
  // Control register bit positions
  localparam int CTRL_ON = 0;
  localparam int CTRL_OFF = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_CAL = 31;
  // Configuration register field positions
  localparam int CFG_DMA_EN = 0;
  localparam int CFG_DMA_CIRC = 1;
  localparam int CFG_SCAN_DOWN = 2;
  localparam int CFG_RES_LO = 3;
  localparam int CFG_ALIGN_LEFT = 5;
  localparam int CFG_TRG_LO = 6;
  localparam int CFG_EDGE_LO = 10;
  localparam int CFG_OVR_OVERWRITE = 12;
  localparam logic [31:0] CFG_WMASK = 32'h00001dff;
  // Status and mask bit positions
  localparam int STS_READY = 0;
  localparam int STS_EOC = 2;
  localparam int STS_OVR = 4;
  localparam logic [7:0] STS_IMPL = 8'h15;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CFG1_RESET = 32'h00000000;
  // Trigger edge modes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== src/adcc_trig_detect.sv ====
// External trigger source selection and edge detection
`timescale 1ns/1ps
`default_nettype none
module adcc_trig_detect
  import adcc_pkg::*;
#(
  parameter int NUM_TRG = 8
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger inputs and selection
  input wire logic [NUM_TRG-1:0] ext_trig,
  input wire logic [$clog2(NUM_TRG)-1:0] trigger_source_select,
  input wire logic [1:0] trigger_edge_select,
  // Detected edge, one cycle
  output logic trig_hit
);
  logic sel_now, sel_prev_q;

  assign sel_now = ext_trig[trigger_source_select];

  // Source change may fake one edge; config only changes while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel_prev_q <= 1'b0;
    else
      sel_prev_q <= sel_now;
  end

  always_comb
  begin
    case (trigger_edge_select)
      EDGE_RISE: trig_hit = sel_now && !sel_prev_q;
      EDGE_FALL: trig_hit = !sel_now && sel_prev_q;
      EDGE_BOTH: trig_hit = sel_now ^ sel_prev_q;
      default: trig_hit = 1'b0;
    endcase
  end
endmodule // adcc_trig_detect
`default_nettype wire

// ==== testbench/adcc_core_model.sv ====
// Behavioural analog core and DMA controller beside the control block
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // From the control block, and dma_stall from the testbench
  input wire logic core_power_on,
  input wire logic core_cal_run,
  input wire logic core_start_pulse,
  input wire logic core_stop_pulse,
  input wire logic dma_req,
  input wire logic dma_stall,
  // To the control block
  output logic core_ready,
  output logic core_off_done,
  output logic core_cal_done,
  output logic core_eoc,
  output logic [11:0] core_result,
  output logic core_idle,
  output logic dma_ack
);
  logic pwr_q;
  int conv_q, cal_q;
  always_ff @(posedge aclk)
  begin
    pwr_q <= core_power_on & aresetn;
    core_ready <= core_power_on && !pwr_q;
    core_off_done <= !core_power_on && pwr_q;
    cal_q <= core_cal_run ? cal_q + 1 : 0;
    // Long calibration so software sees the bit set
    core_cal_done <= core_cal_run && cal_q == 16;
    if (core_start_pulse)
      conv_q <= 1;
    else if (core_stop_pulse)
      conv_q <= 9;
    else if (conv_q == 10)
      conv_q <= 0;
    else if (conv_q != 0)
      conv_q <= conv_q + 1;
    core_eoc <= conv_q == 3 || conv_q == 7;
    // Result lines toggle when not valid, never hold stale data
    core_result <= conv_q == 3 ? 12'h0a5 : conv_q == 7 ? 12'h0a6 :
      ~core_result;
    core_idle <= conv_q == 9;
    dma_ack <= dma_req && !dma_ack && !dma_stall;
    if (!aresetn)
    begin
      conv_q <= 0;
      cal_q <= 0;
      core_ready <= 1'b0;
      core_off_done <= 1'b0;
      core_cal_done <= 1'b0;
      core_eoc <= 1'b0;
      core_idle <= 1'b0;
      dma_ack <= 1'b0;
    end
  end
endmodule // adcc_core_model
`default_nettype wire

// ==== testbench/adcc_ctrl_properties.sv ====
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_properties
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  // Core and DMA
  input wire logic core_power_on,
  input wire logic core_cal_run,
  input wire logic core_start_pulse,
  input wire logic core_stop_pulse,
  input wire logic core_eoc,
  input wire logic dma_req,
  input wire logic dma_ack
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence ar_taken;
    s_arvalid && s_arready;
  endsequence
  sequence two_cycle_answer(logic rdy, logic vld);
    (!rdy && !vld) ##1 vld;
  endsequence
  a_write_answer_two: assert property (aw_w_taken |=>
    two_cycle_answer(s_awready, s_bvalid))
    else $error("write response not two cycles after beats");
  a_read_answer_two: assert property (ar_taken |=>
    two_cycle_answer(s_arready, s_rvalid))
    else $error("read data not two cycles after address");
  a_unmapped_zero: assert property (s_rvalid && s_rresp == RESP_SLVERR
    |-> s_rdata == 32'h0)
    else $error("error read returned nonzero data");
  a_cal_excludes_on: assert property (!(core_cal_run && core_power_on))
    else $error("calibration and power on together");
  a_start_needs_on: assert property (core_start_pulse |-> core_power_on)
    else $error("start pulse while converter off");
  a_stop_needs_on: assert property (core_stop_pulse |-> core_power_on)
    else $error("stop pulse while converter off");
  a_dma_after_eoc: assert property ($rose(dma_req) |-> $past(core_eoc))
    else $error("dma request without completed conversion");
  a_dma_ack_drop: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request held after acknowledge");
  a_dma_overrun_drop: assert property (dma_req && core_eoc |=> !dma_req)
    else $error("dma request kept over an overrun");
endmodule // adcc_ctrl_properties
`default_nettype wire

// ==== testbench/adcc_ctrl_tb.sv ====
// Register-level testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_tb
  import adcc_pkg::*;
;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, dma_q;
  logic [11:0] s_awaddr, s_araddr, core_result;
  logic [31:0] s_wdata, s_rdata, rdat, v;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, core_resolution, rsp;
  logic core_ready, core_off_done, core_cal_done, core_eoc, core_idle;
  logic core_power_on, core_cal_run, core_start_pulse, core_stop_pulse;
  logic core_scan_down, dma_req, dma_circular, dma_ack, dma_stall;
  logic [7:0] ext_trig;
  int num_errors = 0, checked = 0, n_start = 0, n_stop = 0, n_dma = 0, s0;
  adcc_ctrl #(.ADDR_W(12), .NUM_TRG(8)) u_dut (.aclk, .aresetn,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .core_ready,
    .core_off_done, .core_cal_done, .core_eoc, .core_result, .core_idle,
    .core_power_on, .core_cal_run, .core_start_pulse, .core_stop_pulse,
    .core_scan_down, .core_resolution, .ext_trig, .dma_req, .dma_circular,
    .dma_ack, .irq);
  adcc_core_model u_model (.aclk, .aresetn, .core_power_on, .core_cal_run,
    .core_start_pulse, .core_stop_pulse, .dma_req, .dma_stall, .core_ready,
    .core_off_done, .core_cal_done, .core_eoc, .core_result, .core_idle,
    .dma_ack);
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    dma_q <= dma_req;
    if (core_start_pulse) n_start <= n_start + 1;
    if (core_stop_pulse) n_stop <= n_stop + 1;
    if (dma_req && !dma_q) n_dma <= n_dma + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic lost();
    num_errors++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ready lines are held high, so each task ends on the answer edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready && s_awvalid) s_awvalid <= 1'b0;
      if (s_wready && s_wvalid) s_wvalid <= 1'b0;
      n++;
    end
    while (s_bvalid !== 1'b1 && n < 40);
    rsp = s_bresp;
    if (n >= 40) lost();
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready && s_arvalid) s_arvalid <= 1'b0;
      n++;
    end
    while (s_rvalid !== 1'b1 && n < 40);
    rdat = s_rdata;
    rsp = s_rresp;
    if (n >= 40) lost();
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task automatic wait_clr(input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      rd(ADDR_CTRL);
      n++;
    end
    while ((rdat & m) !== 32'h00000000 && n < 30);
    if (n >= 30) lost();
  endtask
  task automatic conv();
    wr(ADDR_CTRL, 32'h4);
    wait_clr(32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_awvalid, s_wvalid, s_arvalid, dma_stall} = 4'h0;
    {s_awaddr, s_araddr, s_wdata, ext_trig} = '0;
    {s_bready, s_rready, s_wstrb} = 6'h3f;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(ADDR_CTRL, CTRL_RESET);
    rchk(ADDR_CFG1, CFG1_RESET);
    rchk(ADDR_IEN, 32'h0);
    rd(12'h100);
    chk({rdat[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(12'h100, 32'h1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, 32'h2 << i & 32'h16);
      rchk(ADDR_CTRL, 32'h0);
    end
    wr(ADDR_CTRL, 32'h80000000);
    wr(ADDR_CTRL, 32'h1);
    rchk(ADDR_CTRL, 32'h80000000);
    wait_clr(32'h80000000);
    wr(ADDR_CTRL, 32'h1);
    chk(32'(rsp), 32'(RESP_OKAY));
    rchk(ADDR_CTRL, 32'h1);
    rchk(ADDR_STS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(ADDR_IEN, 32'h1);
    rchk(ADDR_IEN, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(ADDR_STS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(ADDR_CTRL, 32'h10);
    rchk(ADDR_CTRL, 32'h1);
    wr(ADDR_CFG1, 32'hffffffff);
    rchk(ADDR_CFG1, CFG_WMASK);
    chk(32'(dma_circular), 32'h1);
    wr(ADDR_CFG1, 32'h2);
    repeat (2) @(posedge aclk);
    chk(32'(dma_circular), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CFG1, 32'(i) << 3 | 32'(i & 1) << 2);
      repeat (2) @(posedge aclk);
      chk(32'(core_resolution), 32'(i));
      chk(32'(core_scan_down), 32'(i & 1));
    end
    // Edge modes, each on its own source, a neighbour toggled first
    for (int m = 1; m < 4; m++)
    begin
      v = 32'(m) << 10 | 32'(m + 4) << 6;
      wr(ADDR_CFG1, v);
      s0 = n_start;
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_CFG1, 32'h0);
      rchk(ADDR_CFG1, v);
      ext_trig[m + 3] <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_trig[m + 3] <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(n_start - s0, 0);
      ext_trig[m + 4] <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_trig[m + 4] <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(n_start - s0, m == 3 ? 2 : 1);
      wait_clr(32'h4);
    end
    wr(ADDR_CFG1, 32'h0);
    s0 = n_stop;
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_CTRL, 32'h10);
    wait_clr(32'h14);
    chk(n_stop - s0, 1);
    rd(ADDR_DATA);
    wr(ADDR_STS, 32'h1f);
    conv();
    rchk(ADDR_STS, 32'h14);
    rchk(ADDR_DATA, 32'h0a5);
    wr(ADDR_CFG1, 32'h1020);
    conv();
    rchk(ADDR_DATA, 32'h0a60);
    wr(ADDR_STS, 32'h1f);
    wr(ADDR_CFG1, 32'h3);
    s0 = n_dma;
    conv();
    chk(n_dma - s0, 2);
    rchk(ADDR_STS, 32'h4);
    dma_stall <= 1'b1;
    s0 = n_dma;
    conv();
    chk(n_dma - s0, 1);
    rchk(ADDR_STS, 32'h14);
    dma_stall <= 1'b0;
    conv();
    rd(ADDR_DATA);
    chk(n_dma - s0, 1);
    wr(ADDR_STS, 32'h10);
    conv();
    chk(n_dma - s0, 3);
    wr(ADDR_CFG1, 32'h1);
    s0 = n_dma;
    conv();
    conv();
    chk(n_dma - s0, 2);
    wr(ADDR_CTRL, 32'h2);
    wait_clr(32'h3);
    chk(32'(core_power_on), 32'h0);
    finish_test();
  end
endmodule // adcc_ctrl_tb
bind adcc_ctrl adcc_ctrl_properties u_props (.aclk, .aresetn, .s_awvalid,
  .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready,
  .s_rdata, .s_rresp, .s_rvalid, .core_power_on, .core_cal_run,
  .core_start_pulse, .core_stop_pulse, .core_eoc, .dma_req, .dma_ack);
`default_nettype wire
